//--- hdl/fupc_top.sv
// Flash user program control: registers, erase sequencer, write gating
// How it works
// - Erase and program only with key A5h
// - Reset clears unlock key to zero
// - Start bit launches erase or hard lock
// - Erase stalls processor for erase period
// - Byte program ignores the start bit
// - Control register acts only in user mode
// - Sectors are 128 bytes, low bits ignored
// - Sector address from high and low bytes
// - Writes into enabled boot area refused
// - Boot area active only when option bit two and boot_disable are zero
// - Boot size from option bits one to zero
// - Reset vector from option bits seven to five
// - Vector and size fields decoded independently
// - User mode erases whole sectors only
// - No sector erase in tool mode
// - Nibble 0110 plus start sets hard lock
// - Start bit clears when erase completes
// - Erase without key leaves start bit set
// - Nibble 0101 selects byte programming
//
// The plain strobed port was left to the implementer.
`include "fupc_cfg.svh"
module fupc_top #(
  parameter int ERASE_CYCLES = `FUPC_ERASE_US * `FUPC_CLK_MHZ
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic tool_mode,
  input wire logic [7:0] opt_byte,
  input wire logic boot_disable,
  input wire logic vec_sel_disable,
  input wire logic tbl_write,
  input wire logic [15:0] tbl_addr,
  input wire logic [7:0] tbl_data,
  output logic cpu_stall,
  output logic erase_req,
  output logic [15:0] erase_addr,
  output logic prog_req,
  output logic [15:0] prog_addr,
  output logic [7:0] prog_data,
  output logic hard_locked,
  output logic [15:0] reset_vector
);
  initial begin
    if (ERASE_CYCLES < 1) begin
      $error("ERASE_CYCLES must be at least one");
    end
  end

  // Straps from pins pass two flops before use
  logic [1:0] tool_sync_r;
  logic [9:0] opt_s1_r; // First stage, read only by second stage
  logic [9:0] opt_s2_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tool_sync_r <= 2'b00;
      opt_s1_r <= 10'h000;
      opt_s2_r <= 10'h000;
    end else begin
      tool_sync_r <= {tool_sync_r[0], tool_mode};
      opt_s1_r <= {vec_sel_disable, boot_disable, opt_byte};
      opt_s2_r <= opt_s1_r;
    end
  end
  logic tool_q;
  assign tool_q = tool_sync_r[1];

  // Option decode
  fupc_pkg::fupc_opt_t opt;
  fupc_opt_decode u_opt (
    .opt_byte(opt_s2_r[7:0]),
    .boot_disable(opt_s2_r[8]),
    .vec_sel_disable(opt_s2_r[9]),
    .opt(opt)
  );

  // Erase timer
  fupc_tmr_if tmr_if ();
  fupc_erase_timer #(.ERASE_CYCLES(ERASE_CYCLES)) u_tmr (
    .clock(clock),
    .reset_n(reset_n),
    .tmr(tmr_if.tmr)
  );

  // Protection check against the boot window
  function automatic logic in_boot(input logic [15:0] a,
                                   input fupc_pkg::fupc_opt_t o);
    in_boot = o.boot_on && a >= `FUPC_BOOT_BASE && a <= o.boot_end;
  endfunction
  // Sector base of an address
  function automatic logic [15:0] sec_base(input logic [15:0] a);
    sec_base = a & `FUPC_SEC_MASK;
  endfunction

  // Register state
  logic [7:0] key_r, key_nxt; // Unlock key
  logic [7:0] opctl_r, opctl_nxt; // Operation control
  logic [7:0] sech_r, sech_nxt; // Sector high byte
  logic [7:0] secl_r, secl_nxt; // Sector low byte
  logic lock_r, lock_nxt; // Hard lock, cleared only by power reset
  fupc_pkg::fupc_state_t st_r, st_nxt;
  logic [7:0] rdata_nxt;
  logic erase_req_nxt, prog_req_nxt;
  logic [15:0] erase_addr_nxt, prog_addr_nxt;
  logic [7:0] prog_data_nxt;
  logic [15:0] sec_addr;
  logic key_ok;
  logic user_mode;
  logic [3:0] sel;
  logic ctl_wr;

  assign sec_addr = sec_base({sech_r, secl_r});
  assign key_ok = key_r == `FUPC_KEY_VALID;
  assign user_mode = ~tool_q;
  assign sel = opctl_r[7:4];
  assign ctl_wr = reg_write && reg_addr == `FUPC_OFS_OPCTL;

  // Register writes, erase sequencing, table-load gating
  always_comb begin
    key_nxt = key_r;
    opctl_nxt = opctl_r;
    sech_nxt = sech_r;
    secl_nxt = secl_r;
    lock_nxt = lock_r;
    st_nxt = st_r;
    erase_req_nxt = 1'b0;
    prog_req_nxt = 1'b0;
    erase_addr_nxt = erase_addr;
    prog_addr_nxt = prog_addr;
    prog_data_nxt = prog_data;
    tmr_if.start = 1'b0;
    // Software writes; control locked out while erase runs
    if (reg_write) begin
      case (reg_addr)
        `FUPC_OFS_KEY: key_nxt = reg_wdata;
        `FUPC_OFS_OPCTL: begin
          if (st_r == fupc_pkg::FUPC_IDLE) begin
            opctl_nxt = reg_wdata;
          end
        end
        `FUPC_OFS_SECH: sech_nxt = reg_wdata;
        `FUPC_OFS_SECL: secl_nxt = reg_wdata;
        default: ;
      endcase
    end
    case (st_r)
      fupc_pkg::FUPC_IDLE: begin
        // Start bit acted upon the cycle after it is written
        if (opctl_r[`FUPC_START_BIT] && user_mode
            && key_ok && !ctl_wr) begin
          if (sel == `FUPC_SEL_ERASE) begin
            if (!lock_r && !in_boot(sec_addr, opt)) begin
              erase_req_nxt = 1'b1;
              erase_addr_nxt = sec_addr;
              tmr_if.start = 1'b1;
              st_nxt = fupc_pkg::FUPC_ERASE;
            end else begin
              opctl_nxt[`FUPC_START_BIT] = 1'b0;
            end
          end else if (sel == `FUPC_SEL_LOCK) begin
            lock_nxt = 1'b1;
            opctl_nxt[`FUPC_START_BIT] = 1'b0;
          end
        end
        // Without the key the start bit simply stays set
      end
      fupc_pkg::FUPC_ERASE: begin
        if (tmr_if.done) begin
          opctl_nxt[`FUPC_START_BIT] = 1'b0;
          st_nxt = fupc_pkg::FUPC_DONE;
        end
      end
      fupc_pkg::FUPC_DONE: st_nxt = fupc_pkg::FUPC_IDLE;
      default: st_nxt = fupc_pkg::FUPC_IDLE;
    endcase
    // Byte program gate; start bit plays no part
    if (tbl_write && user_mode && key_ok && sel == `FUPC_SEL_PROG
        && !lock_r && sec_base(tbl_addr) == sec_addr
        && !in_boot(tbl_addr, opt)) begin
      prog_req_nxt = 1'b1;
      prog_addr_nxt = tbl_addr;
      prog_data_nxt = tbl_data;
    end
  end

  // Read mux, data one cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_read) begin
      case (reg_addr)
        `FUPC_OFS_KEY: rdata_nxt = key_r;
        `FUPC_OFS_OPCTL: rdata_nxt = opctl_r;
        `FUPC_OFS_SECH: rdata_nxt = sech_r;
        `FUPC_OFS_SECL: rdata_nxt = secl_r;
        `FUPC_OFS_STAT: rdata_nxt = {6'h00, lock_r, cpu_stall};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      key_r <= `FUPC_KEY_RST;
      opctl_r <= `FUPC_OPCTL_RST;
      sech_r <= `FUPC_SEC_RST;
      secl_r <= `FUPC_SEC_RST;
      lock_r <= 1'b0;
      st_r <= fupc_pkg::FUPC_IDLE;
      reg_rdata <= 8'h00;
      cpu_stall <= 1'b0;
      erase_req <= 1'b0;
      erase_addr <= 16'h0000;
      prog_req <= 1'b0;
      prog_addr <= 16'h0000;
      prog_data <= 8'h00;
      hard_locked <= 1'b0;
      reset_vector <= `FUPC_VEC_DEF;
    end else begin
      key_r <= key_nxt;
      opctl_r <= opctl_nxt;
      sech_r <= sech_nxt;
      secl_r <= secl_nxt;
      lock_r <= lock_nxt;
      st_r <= st_nxt;
      reg_rdata <= rdata_nxt;
      cpu_stall <= st_nxt == fupc_pkg::FUPC_ERASE;
      erase_req <= erase_req_nxt;
      erase_addr <= erase_addr_nxt;
      prog_req <= prog_req_nxt;
      prog_addr <= prog_addr_nxt;
      prog_data <= prog_data_nxt;
      hard_locked <= lock_nxt;
      reset_vector <= opt.reset_vec;
    end
  end

  // Checker helper: length of the current stall in cycles
  logic [31:0] stall_len_r;
  logic [31:0] stall_len_nxt;
  // Count while stalled, restart from zero otherwise
  always_comb begin
    stall_len_nxt = 32'h0000_0000;
    if (cpu_stall) begin
      stall_len_nxt = stall_len_r + 32'h0000_0001;
    end
  end
  // Registers only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stall_len_r <= 32'h0000_0000;
    end else begin
      stall_len_r <= stall_len_nxt;
    end
  end

  // Checks
  a_prog_needs_key: assert property (@(posedge clock) disable iff (!reset_n)
    prog_req |-> $past(key_ok) && !$past(tool_q))
    else $error("program without key");
  a_key_reset: assert property (@(posedge clock)
    !reset_n |=> key_r == `FUPC_KEY_RST || !reset_n)
    else $error("key not cleared");
  a_erase_stall: assert property (@(posedge clock) disable iff (!reset_n)
    erase_req |-> cpu_stall)
    else $error("erase without stall");
  a_start_clears: assert property (@(posedge clock) disable iff (!reset_n)
    tmr_if.done |=> !opctl_r[`FUPC_START_BIT])
    else $error("start bit kept");
  // Only the idle sequencer holds a refused start; a running erase may end
  a_nokey_keeps: assert property (@(posedge clock) disable iff (!reset_n)
    st_r == fupc_pkg::FUPC_IDLE && opctl_r[`FUPC_START_BIT] && !key_ok
      && !reg_write |=> opctl_r[`FUPC_START_BIT])
    else $error("start bit lost");
  a_boot_guard: assert property (@(posedge clock) disable iff (!reset_n)
    prog_req |-> !$past(in_boot(tbl_addr, opt)))
    else $error("boot area written");
  a_lock_blocks: assert property (@(posedge clock) disable iff (!reset_n)
    hard_locked |-> !prog_req && !erase_req)
    else $error("write under hard lock");
  a_sector_match: assert property (@(posedge clock) disable iff (!reset_n)
    prog_req |-> sec_base(prog_addr) == $past(sec_addr))
    else $error("program outside sector");
  // Erase launch: an accepted start, then request and stall together
  sequence s_erase_go;
    st_r == fupc_pkg::FUPC_IDLE && opctl_r[`FUPC_START_BIT]
      && sel == `FUPC_SEL_ERASE && key_ok && user_mode && !ctl_wr
      && !lock_r && !in_boot(sec_addr, opt);
  endsequence
  sequence s_erase_on;
    (erase_req && cpu_stall) ##1 (!erase_req && cpu_stall);
  endsequence
  a_erase_launch: assert property (@(posedge clock) disable iff (!reset_n)
    s_erase_go |=> s_erase_on)
    else $error("erase launch incomplete");
  a_stall_length: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(cpu_stall) |-> stall_len_r == 32'(ERASE_CYCLES + 1))
    else $error("stall length wrong");
  a_erase_aligned: assert property (@(posedge clock) disable iff (!reset_n)
    erase_req |-> (erase_addr & ~`FUPC_SEC_MASK) == 16'h0000)
    else $error("erase not sector aligned");
  a_lock_sticky: assert property (@(posedge clock) disable iff (!reset_n)
    hard_locked |=> hard_locked)
    else $error("hard lock dropped");
endmodule

//--- hdl/fupc_cfg.svh
// Constants for the flash user program control block
`ifndef FUPC_CFG_SVH
`define FUPC_CFG_SVH
// Register offsets on the plain register port
`define FUPC_OFS_KEY 8'hED
`define FUPC_OFS_OPCTL 8'hEE
`define FUPC_OFS_SECH 8'hEF
`define FUPC_OFS_SECL 8'hF0
`define FUPC_OFS_STAT 8'hF1
// Unlock key and reset values
`define FUPC_KEY_VALID 8'hA5
`define FUPC_KEY_RST 8'h00
`define FUPC_OPCTL_RST 8'h00
`define FUPC_SEC_RST 8'h00
// Operation select nibble codes
`define FUPC_SEL_ERASE 4'hA
`define FUPC_SEL_PROG 4'h5
`define FUPC_SEL_LOCK 4'h6
// Start bit position
`define FUPC_START_BIT 0
// Sector geometry: low byte bits 6..0 ignored
`define FUPC_SEC_MASK 16'hFF80
// Boot area start
`define FUPC_BOOT_BASE 16'h0100
// Boot area ends per size code
`define FUPC_BOOT_END0 16'h01FF
`define FUPC_BOOT_END1 16'h02FF
`define FUPC_BOOT_END2 16'h04FF
`define FUPC_BOOT_END3 16'h08FF
// Reset vectors per selection code
`define FUPC_VEC_DEF 16'h0100
`define FUPC_VEC0 16'h0200
`define FUPC_VEC1 16'h0300
`define FUPC_VEC2 16'h0500
`define FUPC_VEC3 16'h0900
// Erase time in microseconds, clock in MHz
`define FUPC_ERASE_US 4000
`define FUPC_CLK_MHZ 100
`endif

//--- hdl/fupc_pkg.sv
// Types shared by the flash user program control modules
package fupc_pkg;
  // Sequencer states
  typedef enum logic [1:0] {
    FUPC_IDLE,
    FUPC_ERASE,
    FUPC_DONE
  } fupc_state_t;
  // Option byte decode result
  typedef struct packed {
    logic boot_on;
    logic [15:0] boot_end;
    logic [15:0] reset_vec;
  } fupc_opt_t;
endpackage

//--- hdl/fupc_if.sv
// Interface between the controller and its erase timer
interface fupc_tmr_if;
  logic start; // One-cycle start of the erase period
  logic busy; // High while the period runs
  logic done; // One-cycle pulse at the end
  modport ctl (output start, input busy, input done);
  modport tmr (input start, output busy, output done);
endinterface

//--- hdl/fupc_erase_timer.sv
// Erase period counter for the flash user program control
`include "fupc_cfg.svh"
module fupc_erase_timer #(
  parameter int ERASE_CYCLES = `FUPC_ERASE_US * `FUPC_CLK_MHZ
) (
  input wire logic clock,
  input wire logic reset_n,
  fupc_tmr_if.tmr tmr
);
  initial begin
    if (ERASE_CYCLES < 1) begin
      $error("ERASE_CYCLES must be at least one");
    end
  end
  logic [31:0] cnt_r; // Cycles left
  logic [31:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;
  logic done_r;
  logic done_nxt;
  // Count down from the start pulse; restart is ignored while busy
  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (busy_r) begin
      if (cnt_r == 32'h0000_0001) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
      cnt_nxt = cnt_r - 32'h0000_0001;
    end else if (tmr.start) begin
      busy_nxt = 1'b1;
      cnt_nxt = 32'(ERASE_CYCLES);
    end
  end
  // Registers only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 32'h0000_0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end
  assign tmr.busy = busy_r;
  assign tmr.done = done_r;
endmodule

//--- hdl/fupc_opt_decode.sv
// Option byte decode: boot area window and reset vector
`include "fupc_cfg.svh"
module fupc_opt_decode (
  input wire logic [7:0] opt_byte,
  input wire logic boot_disable,
  input wire logic vec_sel_disable,
  output fupc_pkg::fupc_opt_t opt
);
  // Size field and vector field decoded apart from each other
  always_comb begin
    opt.boot_on = ~boot_disable & ~opt_byte[2];
    case (opt_byte[1:0])
      2'h0: opt.boot_end = `FUPC_BOOT_END0;
      2'h1: opt.boot_end = `FUPC_BOOT_END1;
      2'h2: opt.boot_end = `FUPC_BOOT_END2;
      default: opt.boot_end = `FUPC_BOOT_END3;
    endcase
    // Vector ignores the size bits entirely
    if (boot_disable || vec_sel_disable || opt_byte[7]) begin
      opt.reset_vec = `FUPC_VEC_DEF;
    end else begin
      case (opt_byte[6:5])
        2'h0: opt.reset_vec = `FUPC_VEC0;
        2'h1: opt.reset_vec = `FUPC_VEC1;
        2'h2: opt.reset_vec = `FUPC_VEC2;
        default: opt.reset_vec = `FUPC_VEC3;
      endcase
    end
  end
endmodule

//--- testbench/fupc_core_model.sv
// Processor core model: register bus master and table-load writer
module fupc_core_model (
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [7:0] reg_rdata,
  output logic tbl_write,
  output logic [15:0] tbl_addr,
  output logic [7:0] tbl_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    tbl_write = 1'b0;
    tbl_addr = 16'h0000;
    tbl_data = 8'h00;
  end
  // One-cycle write; data inverted after release so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // One-cycle read; data taken once settled in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // One table-load write pulse with address and data
  task automatic tw(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    tbl_addr <= a;
    tbl_data <= d;
    tbl_write <= 1'b1;
    @(posedge clock);
    tbl_write <= 1'b0;
    tbl_data <= ~d;
    tbl_addr <= ~a;
  endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench for the flash user program control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset_n, tool_mode, boot_disable, vec_sel_disable;
  logic [7:0] opt_byte, reg_addr, reg_wdata, reg_rdata, tbl_data, prog_data;
  logic reg_write, reg_read, tbl_write, cpu_stall, erase_req, prog_req;
  logic hard_locked;
  logic [15:0] tbl_addr, erase_addr, prog_addr, reset_vector;
  logic [7:0] rd;
  int num_errors = 0;
  int n_checks = 0;
  int n;
  localparam int ECYC = 20; // Short erase period keeps the run brief
  fupc_top #(.ERASE_CYCLES(ECYC)) dut (.clock(clock), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .tool_mode(tool_mode),
    .opt_byte(opt_byte), .boot_disable(boot_disable),
    .vec_sel_disable(vec_sel_disable), .tbl_write(tbl_write),
    .tbl_addr(tbl_addr), .tbl_data(tbl_data), .cpu_stall(cpu_stall),
    .erase_req(erase_req), .erase_addr(erase_addr), .prog_req(prog_req),
    .prog_addr(prog_addr), .prog_data(prog_data),
    .hard_locked(hard_locked), .reset_vector(reset_vector));
  fupc_core_model core (.clock(clock), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .tbl_write(tbl_write), .tbl_addr(tbl_addr),
    .tbl_data(tbl_data));
  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
    input string msg);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Reset pulse; straps need a few edges to settle afterwards
  task automatic do_reset;
    reset_n <= 1'b0;
    tool_mode <= 1'b0;
    repeat (2) @(posedge clock);
    chk(reset_vector, 16'h0100, "vector in reset");
    reset_n <= 1'b1;
    repeat (5) @(posedge clock);
  endtask
  // Wait for the stall, then measure its length
  task automatic erase_run(input logic [15:0] base);
    n = 0;
    while (cpu_stall !== 1'b1 && n < 10) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 10) begin
      num_errors++;
      $display("[FAIL] %0t erase never started", $time);
      summarize();
    end
    chk(erase_req, 1'b1, "erase pulse");
    chk(erase_addr, base, "erase base");
    n = 0;
    while (cpu_stall === 1'b1 && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 100) begin
      num_errors++;
      $display("[FAIL] %0t erase never ended", $time);
      summarize();
    end
    chk(n[15:0], 16'(ECYC + 1), "stall length");
  endtask
  // Table write and judgement of the program pulse
  task automatic tw(input logic [15:0] a, input logic [7:0] d, input logic ok);
    core.tw(a, d);
    #1;
    chk(prog_req, ok, "program gate");
    if (ok) begin
      chk(prog_addr, a, "program address");
      chk(prog_data, d, "program data");
    end
  endtask
  // Reset values, unmapped read, decoded vector
  task automatic t_reset;
    core.rd(8'hED, rd);
    chk(rd, 8'h00, "key reset");
    core.rd(8'hF1, rd);
    chk(rd, 8'h00, "status reset");
    core.rd(8'hF5, rd);
    chk(rd, 8'h00, "unmapped read");
    chk(reset_vector, 16'h0900, "vector select");
    $display("reset test done");
  endtask
  // Erase refused without key, then run once key arrives
  task automatic t_erase;
    core.wr(8'hED, 8'h5A);
    core.wr(8'hEF, 8'h06);
    core.wr(8'hF0, 8'h9F);
    core.wr(8'hEE, 8'hA1);
    repeat (6) @(posedge clock);
    #1;
    chk(cpu_stall, 1'b0, "erase without key");
    core.rd(8'hEE, rd);
    chk(rd, 8'hA1, "start bit kept");
    core.wr(8'hED, 8'hA5);
    erase_run(16'h0680);
    core.rd(8'hEE, rd);
    chk(rd[0], 1'b0, "start bit cleared");
    $display("erase test done");
  endtask
  // Byte programming with boot, sector and key gates
  task automatic t_prog;
    core.wr(8'hEE, 8'h50);
    core.wr(8'hEF, 8'h01);
    core.wr(8'hF0, 8'h00);
    tw(16'h0140, 8'hCC, 1'b0);
    boot_disable <= 1'b1;
    repeat (5) @(posedge clock);
    tw(16'h0140, 8'hCC, 1'b1);
    core.wr(8'hEF, 8'h06);
    core.wr(8'hF0, 8'h7F);
    tw(16'h0640, 8'h33, 1'b1);
    tw(16'h067F, 8'h34, 1'b1);
    tw(16'h0680, 8'h55, 1'b0);
    core.wr(8'hEE, 8'h51);
    tw(16'h0642, 8'hA3, 1'b1);
    core.wr(8'hED, 8'h00);
    tw(16'h0643, 8'hA4, 1'b0);
    $display("program test done");
  endtask
  // Boot window of size code one, boot erase refused, then no window
  task automatic t_boot;
    boot_disable <= 1'b0;
    opt_byte <= 8'h61;
    repeat (5) @(posedge clock);
    core.wr(8'hED, 8'hA5);
    core.wr(8'hEF, 8'h02);
    core.wr(8'hF0, 8'h80);
    tw(16'h02C0, 8'h5A, 1'b0);
    core.wr(8'hEE, 8'hA1);
    repeat (4) @(posedge clock);
    #1;
    chk(cpu_stall, 1'b0, "boot sector erase");
    core.rd(8'hEE, rd);
    chk(rd, 8'hA0, "boot erase start cleared");
    core.wr(8'hEE, 8'h50);
    core.wr(8'hEF, 8'h03);
    core.wr(8'hF0, 8'h00);
    tw(16'h0300, 8'h5B, 1'b1);
    opt_byte <= 8'h64;
    core.wr(8'hEF, 8'h01);
    core.wr(8'hF0, 8'h00);
    tw(16'h0140, 8'h5C, 1'b1);
    core.wr(8'hED, 8'h00);
    $display("boot test done");
  endtask
  // Erase refused in tool mode
  task automatic t_tool;
    tool_mode <= 1'b1;
    repeat (5) @(posedge clock);
    core.wr(8'hED, 8'hA5);
    core.wr(8'hEE, 8'hA1);
    repeat (8) @(posedge clock);
    #1;
    chk(cpu_stall, 1'b0, "tool mode erase");
    do_reset();
    $display("tool test done");
  endtask
  // Hard lock blocks later program and erase
  task automatic t_lock;
    core.wr(8'hED, 8'hA5);
    core.wr(8'hEE, 8'h61);
    repeat (2) @(posedge clock);
    #1;
    chk(hard_locked, 1'b1, "hard lock set");
    core.rd(8'hF1, rd);
    chk(rd, 8'h02, "lock status");
    core.wr(8'hEE, 8'h50);
    core.wr(8'hEF, 8'h06);
    core.wr(8'hF0, 8'h00);
    tw(16'h0640, 8'h11, 1'b0);
    core.wr(8'hEE, 8'hA1);
    repeat (8) @(posedge clock);
    #1;
    chk(cpu_stall, 1'b0, "locked erase");
    chk(reset_vector, 16'h0900, "vector without size");
    vec_sel_disable <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    chk(reset_vector, 16'h0100, "vector fixed");
    $display("lock test done");
  endtask
  // Main sequence
  initial begin
    reset_n = 1'b0;
    tool_mode = 1'b0;
    boot_disable = 1'b0;
    vec_sel_disable = 1'b0;
    opt_byte = 8'h60;
    do_reset();
    t_reset();
    t_erase();
    t_prog();
    t_boot();
    t_tool();
    t_lock();
    summarize();
  end
endmodule
